// ---- rtl/sltc_consts.vh ----
// Purpose: constants for the serial link transmit control block
// Assumes: AXI4-Lite byte addresses, 32-bit data, 8-bit registers
// Notes: the register index is the printed offset; byte address is index*4
`ifndef SLTC_CONSTS_VH
`define SLTC_CONSTS_VH

// register indexes
`define SLTC_IDX_SYNC_REQ 12'h0203
`define SLTC_IDX_CONTROL 12'h0204
`define SLTC_IDX_TEST 12'h0205
`define SLTC_IDX_DEVID 12'h0206
`define SLTC_IDX_LINK_EN 12'h0200
`define SLTC_IDX_MODE 12'h0201
`define SLTC_IDX_MISC 12'h020A

// reset values
`define SLTC_RST_CONTROL 8'h03
`define SLTC_RST_TEST 8'h00
`define SLTC_RST_DEVID 8'h00
`define SLTC_RST_SYNC_REQ 8'h01
`define SLTC_RST_LINK_EN 8'h01
`define SLTC_RST_MODE 8'h00
`define SLTC_RST_MISC 8'h00

// control field positions
`define SLTC_CTL_SCR 0
`define SLTC_CTL_FMT 1
`define SLTC_CTL_SYNC_LO 2
`define SLTC_CTL_SYNC_HI 3
`define SLTC_CTL_UPPER 4

// sync source encodings
`define SLTC_SYNC_SE 2'h0
`define SLTC_SYNC_TS 2'h1
`define SLTC_SYNC_SOFT 2'h2

// test pattern codes
`define SLTC_TP_NORMAL 5'h00
`define SLTC_TP_PRBS7 5'h01
`define SLTC_TP_PRBS15 5'h02
`define SLTC_TP_PRBS23 5'h03
`define SLTC_TP_RAMP 5'h04
`define SLTC_TP_TRANSPORT 5'h05
`define SLTC_TP_D215 5'h06
`define SLTC_TP_K285 5'h07
`define SLTC_TP_ILA 5'h08
`define SLTC_TP_RPAT 5'h09
`define SLTC_TP_LOW 5'h0A
`define SLTC_TP_HIGH 5'h0B
`define SLTC_TP_PRBS9 5'h0D
`define SLTC_TP_PRBS31 5'h0E
`define SLTC_TP_CLOCK 5'h0F
`define SLTC_TP_K287 5'h10

// test pattern kinds decoded for the lane logic
`define SLTC_KIND_NORMAL 4'h0
`define SLTC_KIND_PRBS 4'h1
`define SLTC_KIND_RAMP 4'h2
`define SLTC_KIND_TRANSPORT 4'h3
`define SLTC_KIND_D215 4'h4
`define SLTC_KIND_K285 4'h5
`define SLTC_KIND_ILA 4'h6
`define SLTC_KIND_RPAT 4'h7
`define SLTC_KIND_LOW 4'h8
`define SLTC_KIND_HIGH 4'h9
`define SLTC_KIND_CLOCK 4'hA
`define SLTC_KIND_K287 4'hB
`define SLTC_KIND_RSVD 4'hF

// prbs polynomial orders
`define SLTC_PRBS_NONE 5'h00
`define SLTC_PRBS_O7 5'h07
`define SLTC_PRBS_O9 5'h09
`define SLTC_PRBS_O15 5'h0F
`define SLTC_PRBS_O23 5'h17
`define SLTC_PRBS_O31 5'h1F

// clock test word
`define SLTC_CLOCK_WORD 16'h00FF

`endif

// ---- rtl/sltc_lane_map.v ----
// Purpose: per-lane enable mask from lane count and upper lane mapping
// Assumes: lane count already limited to the lane total by the caller
// Notes: upper mapping beyond four lanes is undefined; lanes simply clip
`timescale 1ns/1ps
`default_nettype none

module sltc_lane_map #(
	parameter LANES = 8
)(
	// control
	input wire [3:0] lane_count,
	input wire upper_lane_map,
	// result
	output wire [LANES-1:0] lane_used
);

	genvar g;

	////////////////////////////////////////////////////////////////////////
	// one compare per lane: base 0 or base 4, span lane_count
	generate
		for (g = 0; g < LANES; g = g + 1)
		begin : gen_lane
			wire [31:0] idx = g;
			wire [31:0] base =
				upper_lane_map ? 32'h0000_0004 : 32'h0000_0000;
			wire [31:0] top = base + {28'h000_0000, lane_count};
			assign lane_used[g] = (idx >= base) && (idx < top);
		end
	endgenerate

endmodule

`default_nettype wire

// ---- rtl/sltc_top.v ----
// Purpose: register bank and control decode for the serial transmit link
// Assumes: AXI4-Lite slave, 10 MHz clk, synchronous active-high rst
// Notes: sync pins are resynchronised; lane logic reads decoded outputs
//
// How it works
// - upper map clear, lanes zero to count minus one carry the link.
// - upper map set, lanes four to four plus count minus one.
// - sync select zero takes the request from the single-ended pin.
// - sync select one uses the timestamp pair, receiver must be on.
// - sync select two ignores pins; software request bit only.
// - format bit zero offset binary, one two's complement, reset one.
// - in 8b/10b modes scrambler bit gates scrambling, reset enabled.
// - in 64b/66b modes scrambling is always on.
// - test code zero normal; codes 1,2,3,13,14 select prbs orders.
// - codes 4 to 9 select ramp, transport, d21.5, k28.5, ila, rpat.
// - 10 low, 11 high, 15 clock word, 16 k28.7; others reserved.
// - writable eight-bit device identifier register, reset zero.
// - the identifier is sent in the second alignment multiframe.
// - software request bit low always requests synchronisation.
// - link enable low holds the link in reset and powered down.
`timescale 1ns/1ps
`default_nettype none
`include "sltc_consts.vh"

module sltc_top #(
	parameter LANES = 8
)(
	// clock and reset
	input wire clk,
	input wire rst,
	// axi4-lite write address
	input wire [15:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [15:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// link side status from the link layer
	input wire link_uses_64b66b,
	input wire [3:0] link_lane_count,
	// sync pins from the receiver
	input wire single_ended_sync_pin,
	input wire timestamp_pin_pair,
	// decoded controls to the link logic
	output reg link_reset,
	output reg serializer_power_down,
	output reg link_clock_gate_off,
	output reg [LANES-1:0] lane_used,
	output reg sync_request,
	output reg sample_twos_complement,
	output reg scramble_on,
	output reg [3:0] test_kind,
	output reg [4:0] prbs_order,
	output reg [15:0] clock_word,
	output reg [7:0] ila_device_identifier,
	output reg [5:0] link_mode_select,
	output reg timestamp_receiver_on
);

	////////////////////////////////////////////////////////////////////////
	// registers
	reg [7:0] link_enable_r;
	reg [7:0] link_mode_r;
	reg [7:0] sync_req_r;
	reg [7:0] link_control_r;
	reg [7:0] link_test_select_r;
	reg [7:0] link_device_identifier_r;
	reg [7:0] misc_r;

	// write channel capture, either order
	reg aw_have_r;
	reg w_have_r;
	reg [15:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	// pin synchronisers
	reg se_meta_r;
	reg se_sync_r;
	reg ts_meta_r;
	reg ts_sync_r;
	wire link_enable = link_enable_r[0];
	wire soft_sync_request = sync_req_r[0];
	wire scrambler_on = link_control_r[`SLTC_CTL_SCR];
	wire sample_number_format = link_control_r[`SLTC_CTL_FMT];
	wire [1:0] sync_sel =
		link_control_r[`SLTC_CTL_SYNC_HI:`SLTC_CTL_SYNC_LO];
	wire upper_lane_map = link_control_r[`SLTC_CTL_UPPER];
	wire [4:0] lane_test_pattern = link_test_select_r[4:0];
	wire do_write = aw_have_r && w_have_r && !s_axi_bvalid;
	wire [11:0] w_idx = aw_addr_r[13:2];
	wire w_aligned = (aw_addr_r[1:0] == 2'b00) && (aw_addr_r[15:14] == 2'b00);
	wire r_aligned = (s_axi_araddr[1:0] == 2'b00) &&
		(s_axi_araddr[15:14] == 2'b00);
	wire [11:0] r_idx = r_aligned ? s_axi_araddr[13:2] : 12'h000;
	wire [7:0] wbyte = w_strb_r[0] ? w_data_r[7:0] : 8'h00;
	wire wen = do_write && w_strb_r[0] && w_aligned;
	////////////////////////////////////////////////////////////////////////
	// write address and data taken in either order
	always @(posedge clk)
	begin
		if (rst)
		begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 16'h0000;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_awvalid && !aw_have_r && !s_axi_awready)
			begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && !w_have_r && !s_axi_wready)
			begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b1;
			end
			if (do_write)
			begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// unmapped or misaligned address answers slverr
				s_axi_bresp <= (w_aligned && reg_hit(w_idx)) ? 2'b00 : 2'b10;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	// register map membership, shared by both channels
	function reg_hit;
		input [11:0] idx;
		begin
			reg_hit = (idx == `SLTC_IDX_LINK_EN) || (idx == `SLTC_IDX_MODE) ||
				(idx == `SLTC_IDX_SYNC_REQ) || (idx == `SLTC_IDX_CONTROL) ||
				(idx == `SLTC_IDX_TEST) || (idx == `SLTC_IDX_DEVID) ||
				(idx == `SLTC_IDX_MISC);
		end
	endfunction
	////////////////////////////////////////////////////////////////////////
	// register writes; reserved bits are stored as written and read back, except misc bits 7:1, which read as zero
	always @(posedge clk)
	begin
		if (rst)
		begin
			link_enable_r <= `SLTC_RST_LINK_EN;
			link_mode_r <= `SLTC_RST_MODE;
			sync_req_r <= `SLTC_RST_SYNC_REQ;
			link_control_r <= `SLTC_RST_CONTROL;
			link_test_select_r <= `SLTC_RST_TEST;
			link_device_identifier_r <= `SLTC_RST_DEVID;
			misc_r <= `SLTC_RST_MISC;
		end
		else if (wen)
		begin
			case (w_idx)
				`SLTC_IDX_LINK_EN: link_enable_r <= wbyte;
				`SLTC_IDX_MODE: link_mode_r <= wbyte;
				`SLTC_IDX_SYNC_REQ: sync_req_r <= wbyte;
				`SLTC_IDX_CONTROL: link_control_r <= wbyte;
				`SLTC_IDX_TEST: link_test_select_r <= wbyte;
				`SLTC_IDX_DEVID: link_device_identifier_r <= wbyte;
				`SLTC_IDX_MISC: misc_r <= wbyte;
				default: misc_r <= misc_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel: one cycle to rvalid, held until rready
	always @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid)
			begin
				if (s_axi_rready)
					s_axi_rvalid <= 1'b0;
			end
			else if (s_axi_arvalid && !s_axi_arready)
			begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= (r_aligned && reg_hit(r_idx)) ? 2'b00 : 2'b10;
				s_axi_rdata <= {24'h00_0000, rd_mux(r_idx)};
			end
		end
	end
	// read mux; misaligned reads land on index zero and return zero
	function [7:0] rd_mux;
		input [11:0] idx;
		begin
			case (idx)
				`SLTC_IDX_LINK_EN: rd_mux = link_enable_r;
				`SLTC_IDX_MODE: rd_mux = link_mode_r;
				`SLTC_IDX_SYNC_REQ: rd_mux = sync_req_r;
				`SLTC_IDX_CONTROL: rd_mux = link_control_r;
				`SLTC_IDX_TEST: rd_mux = link_test_select_r;
				`SLTC_IDX_DEVID: rd_mux = link_device_identifier_r;
				`SLTC_IDX_MISC: rd_mux = {misc_r[7:1] & 7'h00, sync_request};
				default: rd_mux = 8'h00;
			endcase
		end
	endfunction
	////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for receiver pins, nothing reads the first
	always @(posedge clk)
	begin
		if (rst)
		begin
			se_meta_r <= 1'b1;
			se_sync_r <= 1'b1;
			ts_meta_r <= 1'b1;
			ts_sync_r <= 1'b1;
		end
		else
		begin
			se_meta_r <= single_ended_sync_pin;
			se_sync_r <= se_meta_r;
			ts_meta_r <= timestamp_pin_pair;
			ts_sync_r <= ts_meta_r;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// sync source: pins are active-low requests like the software bit
	reg pin_sync_n;
	always @*
	begin
		case (sync_sel)
			`SLTC_SYNC_SE: pin_sync_n = se_sync_r;
			// timestamp receiver must be on, else the pin reads idle
			`SLTC_SYNC_TS: pin_sync_n = ts_sync_r | ~timestamp_receiver_on;
			`SLTC_SYNC_SOFT: pin_sync_n = 1'b1;
			default: pin_sync_n = 1'b1; // reserved code: pins ignored
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// test code decode into a pattern kind and prbs order
	reg [3:0] kind_nxt;
	reg [4:0] order_nxt;
	always @*
	begin
		kind_nxt = `SLTC_KIND_PRBS;
		order_nxt = `SLTC_PRBS_NONE;
		case (lane_test_pattern)
			`SLTC_TP_NORMAL: kind_nxt = `SLTC_KIND_NORMAL;
			`SLTC_TP_PRBS7: order_nxt = `SLTC_PRBS_O7;
			`SLTC_TP_PRBS15: order_nxt = `SLTC_PRBS_O15;
			`SLTC_TP_PRBS23: order_nxt = `SLTC_PRBS_O23;
			`SLTC_TP_PRBS9: order_nxt = `SLTC_PRBS_O9;
			`SLTC_TP_PRBS31: order_nxt = `SLTC_PRBS_O31;
			`SLTC_TP_RAMP: kind_nxt = `SLTC_KIND_RAMP;
			`SLTC_TP_TRANSPORT: kind_nxt = `SLTC_KIND_TRANSPORT;
			`SLTC_TP_D215: kind_nxt = `SLTC_KIND_D215;
			`SLTC_TP_K285: kind_nxt = `SLTC_KIND_K285;
			`SLTC_TP_ILA: kind_nxt = `SLTC_KIND_ILA;
			`SLTC_TP_RPAT: kind_nxt = `SLTC_KIND_RPAT;
			`SLTC_TP_LOW: kind_nxt = `SLTC_KIND_LOW;
			`SLTC_TP_HIGH: kind_nxt = `SLTC_KIND_HIGH;
			`SLTC_TP_CLOCK: kind_nxt = `SLTC_KIND_CLOCK;
			`SLTC_TP_K287: kind_nxt = `SLTC_KIND_K287;
			// reserved codes flagged, lane logic sends normal data
			default: kind_nxt = `SLTC_KIND_RSVD;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// lane mask from the leaf; count clipped to the lane total
	wire [31:0] lane_total = LANES;
	wire [3:0] count_clip = ({28'h000_0000, link_lane_count} > lane_total) ?
		lane_total[3:0] : link_lane_count;
	wire [LANES-1:0] lane_mask;
	sltc_lane_map #(
		.LANES(LANES)
	) u_lane_map (
		.lane_count(count_clip),
		.upper_lane_map(upper_lane_map),
		.lane_used(lane_mask)
	);

	////////////////////////////////////////////////////////////////////////
	// registered outputs to the link logic
	always @(posedge clk)
	begin
		if (rst)
		begin
			link_reset <= 1'b1;
			serializer_power_down <= 1'b1;
			link_clock_gate_off <= 1'b1;
			lane_used <= {LANES{1'b0}};
			sync_request <= 1'b0;
			sample_twos_complement <= 1'b1;
			scramble_on <= 1'b1;
			test_kind <= `SLTC_KIND_NORMAL;
			prbs_order <= `SLTC_PRBS_NONE;
			clock_word <= `SLTC_CLOCK_WORD;
			ila_device_identifier <= `SLTC_RST_DEVID;
			link_mode_select <= 6'h00;
			timestamp_receiver_on <= 1'b0;
		end
		else
		begin
			// link disabled: held in reset, powered down, clocks gated
			link_reset <= ~link_enable;
			serializer_power_down <= ~link_enable;
			link_clock_gate_off <= ~link_enable;
			// no lane carries data while the link is held off
			lane_used <= link_enable ? lane_mask : {LANES{1'b0}};
			// software bit low requests sync whatever the source
			sync_request <= ~soft_sync_request | ~pin_sync_n;
			sample_twos_complement <= sample_number_format;
			// 64b/66b ignores the control bit and always scrambles
			scramble_on <= link_uses_64b66b | scrambler_on;
			test_kind <= kind_nxt;
			prbs_order <= order_nxt;
			clock_word <= `SLTC_CLOCK_WORD;
			// carried into the second multiframe by the alignment sender
			ila_device_identifier <= link_device_identifier_r;
			link_mode_select <= link_mode_r[5:0];
			timestamp_receiver_on <= misc_r[0];
		end
	end

endmodule

`default_nettype wire

// ---- tb/sltc_far_rx.sv ----
// Purpose: behavioural far-side receiver for the transmit control block
// Assumes: bench calls the tasks; pins change just after a rising edge
// Notes: sync pins are low-true, idle high between requests
`timescale 1ns/1ps
`default_nettype none
module sltc_far_rx (
	// clock
	input wire logic clk,
	// mode status
	output logic link_uses_64b66b,
	output logic [3:0] link_lane_count,
	// sync requests
	output logic single_ended_sync_pin,
	output logic timestamp_pin_pair
);
	// idle: 8b/10b, two lanes, nothing requested
	initial
	begin
		link_uses_64b66b = 1'b0;
		link_lane_count = 4'h2;
		single_ended_sync_pin = 1'b1;
		timestamp_pin_pair = 1'b1;
	end
	task set_link(input logic b, input logic [3:0] l);
		@(posedge clk);
		link_uses_64b66b <= b;
		link_lane_count <= l;
	endtask
	task set_sync(input logic se, input logic ts);
		@(posedge clk);
		single_ended_sync_pin <= se;
		timestamp_pin_pair <= ts;
	endtask
endmodule
`default_nettype wire

// ---- tb/sltc_props.sv ----
// Purpose: port checks for the transmit control block
// Assumes: one clock, synchronous active-high rst
// Notes: bound onto sltc_top from the bench top
`timescale 1ns/1ps
`default_nettype none
module sltc_props #(
	parameter LANES = 8
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// link side
	input wire logic link_uses_64b66b,
	input wire logic [3:0] link_lane_count,
	input wire logic link_reset,
	input wire logic serializer_power_down,
	input wire logic link_clock_gate_off,
	input wire logic [LANES-1:0] lane_used,
	input wire logic scramble_on,
	input wire logic [3:0] test_kind,
	input wire logic [4:0] prbs_order,
	input wire logic [15:0] clock_word
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	// all three off controls move together and blank the lanes
	chk_link_off:
		assert property (serializer_power_down == link_reset &&
			link_clock_gate_off == link_reset && (!link_reset || lane_used == '0))
		else $error("link off outputs disagree");
	// skip the enable edge and count changes; the mask trails the lane count by one clock
	chk_lane_count:
		assert property (!link_reset && $past(!link_reset) &&
			$stable(link_lane_count) |-> $countones(lane_used) == link_lane_count)
		else $error("lane mask count wrong");
	chk_scr_forced:
		assert property (link_uses_64b66b && $past(link_uses_64b66b) |->
			scramble_on)
		else $error("64b66b mode without scrambling");
	chk_prbs_set:
		assert property (test_kind == 4'h1 |->
			prbs_order inside {5'h07, 5'h09, 5'h0F, 5'h17, 5'h1F})
		else $error("prbs kind with bad order");
	chk_prbs_clear:
		assert property (test_kind != 4'h1 |-> prbs_order == 5'h00)
		else $error("prbs order without prbs kind");
	chk_clock_word:
		assert property (clock_word == 16'h00FF)
		else $error("clock test word wrong");
	chk_b_bound:
		assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |->
			##[1:4] s_axi_bvalid)
		else $error("write response late");
	chk_r_with_ar:
		assert property ($rose(s_axi_arready) |-> s_axi_rvalid)
		else $error("read data not with address accept");
	chk_r_drop:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data held after accept");
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
	cov_upper: cover property (lane_used[4] && !lane_used[0]);
	cov_prbs: cover property (test_kind == 4'h1);
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the transmit control block
// Assumes: 10 MHz clk, axi4-lite master tasks, far side in rx
// Notes: byte address is register index times four
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam LANES = 8;
	localparam [15:0] A_EN = 16'h0800, A_SYN = 16'h080C, A_CTL = 16'h0810;
	localparam [15:0] A_TST = 16'h0814, A_DEV = 16'h0818, A_MSC = 16'h0828;
	logic clk = 1'b0, rst = 1'b1;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0, link_lane_count, test_kind;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, link_uses_64b66b, single_ended_sync_pin;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic timestamp_pin_pair, link_reset, serializer_power_down;
	logic link_clock_gate_off, sync_request, sample_twos_complement;
	logic scramble_on, timestamp_receiver_on;
	logic [LANES-1:0] lane_used;
	logic [4:0] prbs_order;
	logic [15:0] clock_word;
	logic [7:0] ila_device_identifier;
	logic [5:0] link_mode_select;
	int error_cnt = 0, compares = 0;
	always #50 clk = ~clk;
	sltc_top #(.LANES(LANES)) dut (.*);
	sltc_far_rx rx (.*);
	////////////////////////////////////////////////////////////////////////
	task final_report;
		if (error_cnt == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// each channel released on the edge that takes it
	task wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			n++;
		end
		while (s_axi_bvalid !== 1'b1 && n < 20);
		s_axi_bready <= 1'b0;
		if (n >= 20)
		begin
			error_cnt++;
			final_report;
		end
		chk("bresp", er, s_axi_bresp);
	endtask
	task wrk(input logic [15:0] a, input logic [7:0] d);
		wr(a, {24'h00_0000, d}, 4'hF, 2'h0);
		repeat (2) @(posedge clk);
	endtask
	task rd(input logic [15:0] a, input logic [1:0] er, input logic [31:0] e);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			n++;
		end
		while (s_axi_rvalid !== 1'b1 && n < 20);
		s_axi_rready <= 1'b0;
		if (n >= 20)
		begin
			error_cnt++;
			final_report;
		end
		chk("rresp", er, s_axi_rresp);
		chk("rdata", e, s_axi_rdata);
	endtask
	function logic [3:0] ekind(input logic [4:0] c);
		if (c >= 5'h04 && c <= 5'h0B)
			return c[3:0] - 4'h2;
		case (c)
			5'h00: return 4'h0;
			5'h01, 5'h02, 5'h03, 5'h0D, 5'h0E: return 4'h1;
			5'h0F: return 4'hA;
			5'h10: return 4'hB;
			default: return 4'hF;
		endcase
	endfunction
	function logic [4:0] eprbs(input logic [4:0] c);
		case (c)
			5'h01: return 5'h07;
			5'h02: return 5'h0F;
			5'h03: return 5'h17;
			5'h0D: return 5'h09;
			5'h0E: return 5'h1F;
			default: return 5'h00;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		rd(A_CTL, 2'h0, 32'h0000_0003);
		rd(A_TST, 2'h0, 32'h0000_0000);
		rd(A_DEV, 2'h0, 32'h0000_0000);
		chk("twos", 32'h0000_0001, sample_twos_complement);
		chk("scr", 32'h0000_0001, scramble_on);
		rd(16'h0820, 2'h2, 32'h0000_0000);
		rd(16'h0811, 2'h2, 32'h0000_0000);
		wr(16'h0820, 32'h0000_00FF, 4'hF, 2'h2);
	endtask
	// upper bus bits dropped, strobe-less write ignored
	task t_dev;
		wr(A_DEV, 32'hFFFF_FF5A, 4'hF, 2'h0);
		wr(A_DEV, 32'h0000_00A5, 4'h0, 2'h0);
		rd(A_DEV, 2'h0, 32'h0000_005A);
		chk("ila_id", 32'h0000_005A, ila_device_identifier);
		wrk(16'h0804, 8'h2A);
		chk("link_mode", 32'h0000_002A, link_mode_select);
	endtask
	// whole code space with link off in an 8b/10b mode
	task t_test;
		wrk(A_EN, 8'h00);
		for (int c = 0; c < 32; c++)
		begin
			wrk(A_TST, c[7:0]);
			chk("test_kind", ekind(c[4:0]), test_kind);
			chk("prbs_order", eprbs(c[4:0]), prbs_order);
		end
		wrk(A_TST, 8'h00);
	endtask
	task t_fmt;
		wrk(A_CTL, 8'h00);
		chk("twos", 32'h0000_0000, sample_twos_complement);
		chk("scr", 32'h0000_0000, scramble_on);
		rx.set_link(1'b1, 4'h4);
		repeat (3) @(posedge clk);
		chk("scr", 32'h0000_0001, scramble_on);
		rx.set_link(1'b0, 4'h4);
		repeat (3) @(posedge clk);
		chk("scr", 32'h0000_0000, scramble_on);
		wrk(A_CTL, 8'h03);
	endtask
	task ln(input logic [3:0] l, input logic up, input logic [7:0] e);
		wrk(A_EN, 8'h00);
		chk("link_reset", 32'h0000_0001, link_reset);
		chk("lanes_off", 32'h0000_0000, lane_used);
		rx.set_link(1'b0, l);
		wrk(A_CTL, {3'h0, up, 4'h3});
		wrk(A_EN, 8'h01);
		chk("lane_used", e, lane_used);
	endtask
	task sy(input logic [7:0] c, input logic se, input logic ts,
		input logic sb, input logic e);
		wrk(A_CTL, c);
		wrk(A_SYN, {7'h00, sb});
		rx.set_sync(se, ts);
		repeat (5) @(posedge clk);
		chk("sync_request", e, sync_request);
	endtask
	task t_sync;
		wrk(A_EN, 8'h00);
		wrk(A_MSC, 8'h01);
		chk("ts_rx_on", 32'h0000_0001, timestamp_receiver_on);
		sy(8'h03, 1'b0, 1'b1, 1'b1, 1'b1);
		sy(8'h03, 1'b1, 1'b0, 1'b1, 1'b0);
		sy(8'h07, 1'b1, 1'b0, 1'b1, 1'b1);
		sy(8'h07, 1'b0, 1'b1, 1'b1, 1'b0);
		sy(8'h0B, 1'b0, 1'b0, 1'b1, 1'b0);
		sy(8'h0B, 1'b1, 1'b1, 1'b0, 1'b1);
		sy(8'h03, 1'b1, 1'b1, 1'b0, 1'b1);
		rd(A_MSC, 2'h0, 32'h0000_0001);
		// receiver off: the timestamp pair no longer requests sync
		wrk(A_MSC, 8'h00);
		chk("ts_rx_on", 32'h0000_0000, timestamp_receiver_on);
		sy(8'h07, 1'b1, 1'b0, 1'b1, 1'b0);
	endtask
	// second reset in mid-run brings registers and outputs back
	task t_rst2;
		wrk(A_DEV, 8'h77);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk("link_reset", 32'h0000_0001, link_reset);
		rd(A_DEV, 2'h0, 32'h0000_0000);
		chk("link_reset", 32'h0000_0000, link_reset);
		chk("sync_request", 32'h0000_0000, sync_request);
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_dev;
		t_test;
		t_fmt;
		ln(4'h4, 1'b0, 8'h0F);
		ln(4'h4, 1'b1, 8'hF0);
		ln(4'h2, 1'b1, 8'h30);
		ln(4'h8, 1'b0, 8'hFF);
		t_sync;
		t_rst2;
		final_report;
	end
endmodule
bind sltc_top sltc_props #(.LANES(LANES)) u_props (.*);
`default_nettype wire
